/* src/drbk_backup.sv */
// Purpose: Saves the data register array to non-volatile store and restores a window.
// Assumes: Data register reads return data one cycle after the address is shown.
// Notes:   Requests are sampled only on the scan end tick while the engine is idle.
//
// Contract
// - Status shows 1 busy, 2 on success.
// - Unreachable store or missing cartridge gives 3.
// - Restore with zero count gives 4.
// - Start beyond highest index gives 4.
// - Start plus count past end gives 4.
// - Restore without valid image gives 5.
// - Interrupted save leaves image invalid, gives 5.
// - Save request copies whole array to store.
// - After save, post status, clear flag.
// - Both requests: save, restore, post, clear both.
// - Restore copies window, posts status, clears flag.
// - Array spans 0..399 small, 0..1999 large.

module drbk_backup
    import drbk_pkg::*;
(
    input  wire logic                    core_clk_in,
    input  wire logic                    nrst_in,
    input  wire logic                    scan_end_in,
    input  wire logic                    model_small_in,
    input  wire logic                    cart_only_in,
    input  wire logic                    cart_present_in,
    input  wire logic [7:0]              reg_addr_in,
    input  wire logic [15:0]             reg_wdata_in,
    input  wire logic                    reg_wr_in,
    input  wire logic                    reg_rd_in,
    output logic      [15:0]             reg_rdata_out,
    output logic                         irq_out,
    output drbk_pkg::drbk_nv_req_type    nv_req_out,
    input  wire drbk_pkg::drbk_nv_rsp_type nv_rsp_in,
    output drbk_pkg::drbk_dreg_type      dreg_out,
    input  wire logic [15:0]             dreg_rdata_in
);
    import drbk_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    drbk_state_type state_q,   state_d;
    logic [1:0]     flags_q,   flags_d;
    logic [15:0]    status_q,  status_d;
    logic [15:0]    start_q,   start_d;
    logic [15:0]    count_q,   count_d;
    logic [15:0]    addr_q,    addr_d;
    logic [15:0]    left_q,    left_d;
    logic [15:0]    data_q,    data_d;
    logic           both_q,    both_d;
    logic [1:0]     irq_st_q,  irq_st_d;
    logic [1:0]     irq_msk_q, irq_msk_d;
    logic [15:0]    rdata_q,   rdata_d;

    logic [15:0]    last_idx;
    logic [16:0]    end_sum;
    logic [16:0]    end_lim;
    logic           no_access;
    logic [15:0]    rs_code;
    logic           finish;
    logic [15:0]    fin_code;

    // ----------------------------------------------------------------
    // Restore argument checks
    // ----------------------------------------------------------------
    // A missing cartridge outranks bad arguments, so code 3 is tried first.
    always_comb begin
        last_idx  = model_small_in ? LAST_IDX_SMALL : LAST_IDX_LARGE;
        end_sum   = {1'b0, start_q} + {1'b0, count_q};
        end_lim   = {1'b0, last_idx} + 17'h00001;
        no_access = cart_only_in && !cart_present_in;
        if (no_access) begin
            rs_code = CODE_NO_ACCESS;
        end else if (count_q == RST_WORD) begin
            rs_code = CODE_BAD_ARGS;
        end else if (start_q > last_idx) begin
            rs_code = CODE_BAD_ARGS;
        end else if (end_sum > end_lim) begin
            rs_code = CODE_BAD_ARGS;
        end else begin
            rs_code = RST_WORD;
        end
    end

    // ----------------------------------------------------------------
    // Transfer engine
    // ----------------------------------------------------------------
    // Checks run before any array write, so a rejected
    // restore leaves the whole array untouched.
    always_comb begin
        state_d  = state_q;
        addr_d   = addr_q;
        left_d   = left_q;
        data_d   = data_q;
        both_d   = both_q;
        finish   = 1'b0;
        fin_code = CODE_OK;
        case (state_q)
            ST_IDLE: begin
                if (scan_end_in && flags_q[CTRL_SAVE_BIT]) begin
                    both_d = flags_q[CTRL_RESTORE_BIT];
                    if (no_access) begin
                        finish   = 1'b1;
                        fin_code = CODE_NO_ACCESS;
                    end else begin
                        addr_d  = MARK_ADDR;
                        state_d = ST_SV_INV;
                    end
                end else if (scan_end_in && flags_q[CTRL_RESTORE_BIT]) begin
                    both_d = 1'b0;
                    if (rs_code != RST_WORD) begin
                        finish   = 1'b1;
                        fin_code = rs_code;
                    end else begin
                        addr_d  = MARK_ADDR;
                        state_d = ST_RS_CHK;
                    end
                end
            end
            ST_SV_INV: begin
                // Image is marked invalid first so a cut-off save is detected.
                if (nv_rsp_in.ack) begin
                    if (nv_rsp_in.err) begin
                        finish   = 1'b1;
                        fin_code = CODE_NO_ACCESS;
                        state_d  = ST_IDLE;
                    end else begin
                        addr_d  = RST_WORD;
                        state_d = ST_SV_RD;
                    end
                end
            end
            ST_SV_RD: begin
                state_d = ST_SV_CAP;
            end
            ST_SV_CAP: begin
                // Array data arrives one cycle after the index is shown.
                data_d  = dreg_rdata_in;
                state_d = ST_SV_WR;
            end
            ST_SV_WR: begin
                if (nv_rsp_in.ack) begin
                    if (nv_rsp_in.err) begin
                        finish   = 1'b1;
                        fin_code = CODE_NO_ACCESS;
                        state_d  = ST_IDLE;
                    end else if (addr_q == last_idx) begin
                        addr_d  = MARK_ADDR;
                        state_d = ST_SV_MARK;
                    end else begin
                        addr_d  = addr_q + 16'h0001;
                        state_d = ST_SV_RD;
                    end
                end
            end
            ST_SV_MARK: begin
                // The valid mark goes last, after every word has landed.
                if (nv_rsp_in.ack) begin
                    if (nv_rsp_in.err) begin
                        finish   = 1'b1;
                        fin_code = CODE_NO_ACCESS;
                        state_d  = ST_IDLE;
                    end else if (both_q && rs_code != RST_WORD) begin
                        finish   = 1'b1;
                        fin_code = rs_code;
                        state_d  = ST_IDLE;
                    end else if (both_q) begin
                        state_d = ST_RS_CHK;
                    end else begin
                        finish  = 1'b1;
                        state_d = ST_IDLE;
                    end
                end
            end
            ST_RS_CHK: begin
                if (nv_rsp_in.ack) begin
                    if (nv_rsp_in.err) begin
                        finish   = 1'b1;
                        fin_code = CODE_NO_ACCESS;
                        state_d  = ST_IDLE;
                    end else if (nv_rsp_in.rdata != VALID_MARK) begin
                        finish   = 1'b1;
                        fin_code = CODE_NO_IMAGE;
                        state_d  = ST_IDLE;
                    end else begin
                        addr_d  = start_q;
                        left_d  = count_q;
                        state_d = ST_RS_RD;
                    end
                end
            end
            ST_RS_RD: begin
                // A store error here keeps the words already copied.
                if (nv_rsp_in.ack) begin
                    if (nv_rsp_in.err) begin
                        finish   = 1'b1;
                        fin_code = CODE_NO_ACCESS;
                        state_d  = ST_IDLE;
                    end else begin
                        data_d  = nv_rsp_in.rdata;
                        state_d = ST_RS_WR;
                    end
                end
            end
            ST_RS_WR: begin
                // One array write per store word, at the same index.
                addr_d = addr_q + 16'h0001;
                left_d = left_q - 16'h0001;
                if (left_q == 16'h0001) begin
                    finish  = 1'b1;
                    state_d = ST_IDLE;
                end else begin
                    state_d = ST_RS_RD;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Software registers and status
    // ----------------------------------------------------------------
    always_comb begin
        flags_d   = flags_q;
        status_d  = status_q;
        start_d   = start_q;
        count_d   = count_q;
        irq_msk_d = irq_msk_q;
        irq_st_d  = irq_st_q;
        rdata_d   = RST_WORD;
        if (state_q == ST_IDLE && state_d != ST_IDLE) begin
            status_d = CODE_BUSY;
        end
        // A software write in the finishing cycle wins over the clear.
        if (finish) begin
            status_d = fin_code;
            flags_d  = RST_FLAGS;
        end
        if (reg_wr_in) begin
            case (reg_addr_in)
                REG_CTRL: begin
                    flags_d = reg_wdata_in[1:0];
                end
                REG_START: begin
                    start_d = reg_wdata_in;
                end
                REG_COUNT: begin
                    count_d = reg_wdata_in;
                end
                REG_IRQ_MASK: begin
                    irq_msk_d = reg_wdata_in[IRQ_W-1:0];
                end
                default: begin
                end
            endcase
        end
        if (reg_rd_in) begin
            case (reg_addr_in)
                REG_CTRL:       rdata_d = {14'h0000, flags_q};
                REG_STATUS:     rdata_d = status_q;
                REG_START:      rdata_d = start_q;
                REG_COUNT:      rdata_d = count_q;
                REG_IRQ_STATUS: rdata_d = {14'h0000, irq_st_q};
                REG_IRQ_MASK:   rdata_d = {14'h0000, irq_msk_q};
                default:        rdata_d = RST_WORD;
            endcase
            if (reg_addr_in == REG_IRQ_STATUS) begin
                irq_st_d = RST_IRQ;
            end
        end
        // A completion in the same cycle as the clearing read is kept.
        if (finish) begin
            irq_st_d[IRQ_DONE_BIT] = 1'b1;
            irq_st_d[IRQ_ERR_BIT]  = irq_st_d[IRQ_ERR_BIT] | (fin_code != CODE_OK);
        end
    end

    // Only registering here; every next value is formed above.
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_q   <= ST_IDLE;
            flags_q   <= RST_FLAGS;
            status_q  <= RST_WORD;
            start_q   <= RST_WORD;
            count_q   <= RST_WORD;
            addr_q    <= RST_WORD;
            left_q    <= RST_WORD;
            data_q    <= RST_WORD;
            both_q    <= 1'b0;
            irq_st_q  <= RST_IRQ;
            irq_msk_q <= RST_IRQ;
            rdata_q   <= RST_WORD;
        end else begin
            state_q   <= state_d;
            flags_q   <= flags_d;
            status_q  <= status_d;
            start_q   <= start_d;
            count_q   <= count_d;
            addr_q    <= addr_d;
            left_q    <= left_d;
            data_q    <= data_d;
            both_q    <= both_d;
            irq_st_q  <= irq_st_d;
            irq_msk_q <= irq_msk_d;
            rdata_q   <= rdata_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    always_comb begin
        reg_rdata_out     = rdata_q;
        irq_out           = |(irq_st_q & irq_msk_q);
        // The request is a level that stands until the store acknowledges it.
        nv_req_out.req    = (state_q == ST_SV_INV) || (state_q == ST_SV_WR)
                         || (state_q == ST_SV_MARK) || (state_q == ST_RS_CHK)
                         || (state_q == ST_RS_RD);
        nv_req_out.write  = (state_q == ST_SV_INV) || (state_q == ST_SV_WR)
                         || (state_q == ST_SV_MARK);
        nv_req_out.addr   = addr_q;
        if (state_q == ST_SV_INV) begin
            nv_req_out.wdata = INVALID_MARK;
        end else if (state_q == ST_SV_MARK) begin
            nv_req_out.wdata = VALID_MARK;
        end else begin
            nv_req_out.wdata = data_q;
        end
        dreg_out.we       = (state_q == ST_RS_WR);
        dreg_out.addr     = addr_q;
        dreg_out.wdata    = data_q;
    end

endmodule

/* src/drbk_pkg.sv */
// Purpose: Shared constants and types of the data register backup block.
// Assumes: 16-bit data registers and a word-wide non-volatile store port.
// Notes:   Register offsets are byte addresses on the plain register port.

package drbk_pkg;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------------
    // Register map and fields
    // ----------------------------------------------------------------
    localparam int         ADDR_W           = 8;
    localparam int         DATA_W           = 16;
    localparam logic [7:0] REG_CTRL         = 8'h00;
    localparam logic [7:0] REG_STATUS       = 8'h04;
    localparam logic [7:0] REG_START        = 8'h08;
    localparam logic [7:0] REG_COUNT        = 8'h0c;
    localparam logic [7:0] REG_IRQ_STATUS   = 8'h10;
    localparam logic [7:0] REG_IRQ_MASK     = 8'h14;
    localparam int         CTRL_SAVE_BIT    = 0;
    localparam int         CTRL_RESTORE_BIT = 1;
    localparam int         IRQ_DONE_BIT     = 0;
    localparam int         IRQ_ERR_BIT      = 1;
    localparam int         IRQ_W            = 2;

    // ----------------------------------------------------------------
    // Reset values and status codes
    // ----------------------------------------------------------------
    localparam logic [15:0] RST_WORD        = 16'h0000;
    localparam logic [1:0]  RST_FLAGS       = 2'h0;
    localparam logic [1:0]  RST_IRQ         = 2'h0;
    localparam logic [15:0] CODE_BUSY       = 16'h0001;
    localparam logic [15:0] CODE_OK         = 16'h0002;
    localparam logic [15:0] CODE_NO_ACCESS  = 16'h0003;
    localparam logic [15:0] CODE_BAD_ARGS   = 16'h0004;
    localparam logic [15:0] CODE_NO_IMAGE   = 16'h0005;

    // ----------------------------------------------------------------
    // Array geometry and image marker
    // ----------------------------------------------------------------
    localparam logic [15:0] LAST_IDX_SMALL  = 16'h018f;
    localparam logic [15:0] LAST_IDX_LARGE  = 16'h07cf;
    localparam logic [15:0] MARK_ADDR       = 16'h07d0;
    // Marker value is arbitrary; it only has to differ from erased contents.
    localparam logic [15:0] VALID_MARK      = 16'ha5c3;
    localparam logic [15:0] INVALID_MARK    = 16'h0000;

    typedef enum logic [8:0] {
        ST_IDLE    = 9'h001,
        ST_SV_INV  = 9'h002,
        ST_SV_RD   = 9'h004,
        ST_SV_CAP  = 9'h008,
        ST_SV_WR   = 9'h010,
        ST_SV_MARK = 9'h020,
        ST_RS_CHK  = 9'h040,
        ST_RS_RD   = 9'h080,
        ST_RS_WR   = 9'h100
    } drbk_state_type;

    typedef struct packed {
        logic        req;
        logic        write;
        logic [15:0] addr;
        logic [15:0] wdata;
    } drbk_nv_req_type;

    typedef struct packed {
        logic        ack;
        logic        err;
        logic [15:0] rdata;
    } drbk_nv_rsp_type;

    typedef struct packed {
        logic        we;
        logic [15:0] addr;
        logic [15:0] wdata;
    } drbk_dreg_type;

endpackage

/* bench/drbk_backup_monitor.sv */
// Purpose: Port-level checks of the backup engine.
// Assumes: One clock domain with an asynchronous active-low reset.
// Notes:   The request flags live inside the engine, so checks key on store and array ports.
module drbk_backup_monitor
    import drbk_pkg::*;
(
    input wire logic                      core_clk_in,
    input wire logic                      nrst_in,
    input wire logic                      scan_end_in,
    input wire logic                      model_small_in,
    input wire logic                      cart_only_in,
    input wire logic                      cart_present_in,
    input wire logic [7:0]                reg_addr_in,
    input wire logic [15:0]               reg_wdata_in,
    input wire logic                      reg_wr_in,
    input wire logic                      reg_rd_in,
    input wire logic [15:0]               reg_rdata_out,
    input wire logic                      irq_out,
    input wire drbk_pkg::drbk_nv_req_type nv_req_out,
    input wire drbk_pkg::drbk_nv_rsp_type nv_rsp_in,
    input wire drbk_pkg::drbk_dreg_type   dreg_out,
    input wire logic [15:0]               dreg_rdata_in
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [1:0]  mask_q;
    logic        mapped;
    logic [15:0] last_idx;

    assign mapped = reg_addr_in inside {REG_CTRL, REG_STATUS, REG_START, REG_COUNT,
                                        REG_IRQ_STATUS, REG_IRQ_MASK};
    assign last_idx = model_small_in ? LAST_IDX_SMALL : LAST_IDX_LARGE;

    // Shadow of the mask, so the interrupt line can be tied to what software wrote.
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            mask_q <= RST_IRQ;
        end else if (reg_wr_in && reg_addr_in == REG_IRQ_MASK) begin
            mask_q <= reg_wdata_in[1:0];
        end
    end

    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);

    rdata_zero_a: assert property ((!reg_rd_in || !mapped) |=> reg_rdata_out == 16'h0000)
        else $error("read data not zero outside a mapped read");
    mask_gate_a: assert property (mask_q == 2'h0 |-> !irq_out)
        else $error("interrupt high while fully masked");
    nv_hold_a: assert property (nv_req_out.req && !nv_rsp_in.ack |=> $stable(nv_req_out))
        else $error("store request changed before its ack");
    we_follow_a: assert property (dreg_out.we |-> $past(nv_rsp_in.ack) && !$past(nv_req_out.write))
        else $error("array write without a store read ack");
    we_data_a: assert property (dreg_out.we |-> dreg_out.wdata == $past(nv_rsp_in.rdata)
        && dreg_out.addr == $past(nv_req_out.addr)) else $error("restored word or index wrong");
    we_pulse_a: assert property (dreg_out.we |=> !dreg_out.we)
        else $error("array write strobe longer than one cycle");
    save_range_a: assert property (nv_req_out.req && nv_req_out.write
        && nv_req_out.addr != MARK_ADDR |-> nv_req_out.addr <= last_idx)
        else $error("save wrote beyond the model range");
    cart_block_a: assert property (cart_only_in && !cart_present_in |-> !$rose(nv_req_out.req))
        else $error("store accessed with no cartridge fitted");

    cover property (dreg_out.we);
    cover property (nv_rsp_in.ack && nv_rsp_in.err);
    cover property (scan_end_in && cart_only_in && !cart_present_in);
    cover property ($rose(irq_out));
endmodule

bind drbk_backup drbk_backup_monitor mon (
    .core_clk_in, .nrst_in, .scan_end_in, .model_small_in, .cart_only_in, .cart_present_in,
    .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .irq_out,
    .nv_req_out, .nv_rsp_in, .dreg_out, .dreg_rdata_in
);

/* bench/drbk_store_model.sv */
// Purpose: Behavioural non-volatile store at the far side of the backup engine.
// Assumes: A held request is answered after lat_in extra cycles with a one-cycle ack.
// Notes:   Contents survive the engine's reset, as a real store survives power loss.
module drbk_store_model
    import drbk_pkg::*;
(
    input  wire logic                      core_clk_in,
    input  wire logic [1:0]                lat_in,
    input  wire logic                      fail_in,
    input  wire drbk_pkg::drbk_nv_req_type nv_req_in,
    output drbk_pkg::drbk_nv_rsp_type      nv_rsp_out
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [15:0] mem [0:2047];
    logic [1:0]  wait_q = 2'h0;

    initial begin
        nv_rsp_out = '0;
        for (int i = 0; i < 2048; i++) begin
            mem[i] = 16'h0000;
        end
    end

    // Read data toggles except on an error-free read ack, so a stale capture never looks right.
    always @(posedge core_clk_in) begin
        nv_rsp_out.ack <= 1'b0;
        nv_rsp_out.err <= 1'b0;
        nv_rsp_out.rdata <= ~nv_rsp_out.rdata;
        if (!nv_req_in.req || nv_rsp_out.ack) begin
            wait_q <= 2'h0;
        end else if (wait_q != lat_in) begin
            wait_q <= wait_q + 2'h1;
        end else begin
            nv_rsp_out.ack <= 1'b1;
            nv_rsp_out.err <= fail_in;
            if (!fail_in && nv_req_in.write) begin
                mem[nv_req_in.addr[10:0]] <= nv_req_in.wdata;
            end else if (!fail_in) begin
                nv_rsp_out.rdata <= mem[nv_req_in.addr[10:0]];
            end
        end
    end
endmodule

/* bench/drbk_backup_test.sv */
// Purpose: Self-checking bench for the backup engine.
// Assumes: Small model for most transfers, large for one full save; the store keeps its contents over reset.
// Notes:   Register reads are queued and compared one cycle later by a watcher.
module drbk_backup_test
    import drbk_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic            core_clk_in = 1'b0, nrst_in = 1'b0, scan_end_in = 1'b0;
    logic            model_small_in = 1'b1, cart_only_in = 1'b0, cart_present_in = 1'b1;
    logic            reg_wr_in = 1'b0, reg_rd_in = 1'b0, irq_out, rd_prev = 1'b0, fail_in = 1'b0;
    logic [1:0]      lat_in = 2'h0;
    logic [7:0]      reg_addr_in = 8'h00;
    logic [15:0]     reg_wdata_in = 16'h0000, reg_rdata_out, dreg_rdata_in = 16'h0000;
    logic [15:0]     lfsr = 16'h002b, darr [0:2047], snap [0:2047], expq [$];
    drbk_nv_req_type nv_req_out;
    drbk_nv_rsp_type nv_rsp_in;
    drbk_dreg_type   dreg_out;
    int              n_mismatch = 0, checked = 0, cyc = 0;
    int              tbl [0:7][0:3] = '{'{1, 0, 1, 5}, '{1, 0, 0, 4}, '{1, 400, 1, 4},
        '{1, 399, 2, 4}, '{1, 399, 1, 5}, '{0, 1999, 2, 4}, '{0, 1999, 1, 5}, '{0, 2000, 1, 4}};

    drbk_backup dut (.core_clk_in, .nrst_in, .scan_end_in, .model_small_in, .cart_only_in,
        .cart_present_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
        .irq_out, .nv_req_out, .nv_rsp_in, .dreg_out, .dreg_rdata_in);
    drbk_store_model store (.core_clk_in, .lat_in, .fail_in, .nv_req_in(nv_req_out),
        .nv_rsp_out(nv_rsp_in));

    always #5 core_clk_in = ~core_clk_in;

    always @(posedge core_clk_in) begin
        dreg_rdata_in <= darr[dreg_out.addr[10:0]];
        if (dreg_out.we === 1'b1) begin
            darr[dreg_out.addr[10:0]] <= dreg_out.wdata;
        end
    end

    always @(posedge core_clk_in) begin
        rd_prev <= reg_rd_in;
        cyc <= cyc + 1;
        if (rd_prev) begin
            check(reg_rdata_out, expq.pop_front());
        end
        if (cyc == 60000) begin
            n_mismatch++;
            complete_run();
        end
    end

    function automatic logic [15:0] nxt(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge core_clk_in);
        reg_wr_in <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        expq.push_back(e);
        @(posedge core_clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge core_clk_in);
        reg_rd_in <= 1'b0;
    endtask

    task automatic tick();
        @(posedge core_clk_in);
        scan_end_in <= 1'b1;
        @(posedge core_clk_in);
        scan_end_in <= 1'b0;
    endtask

    task automatic rst();
        nrst_in <= 1'b0;
        repeat (5) @(posedge core_clk_in);
        nrst_in <= 1'b1;
        wr(REG_IRQ_MASK, 16'h0003);
    endtask

    // Raises the flags, waits for the interrupt, then reads the outcome back.
    task automatic op(input logic [1:0] fl, input logic [15:0] code, input logic mid);
        int n;
        lfsr = nxt(lfsr);
        lat_in <= lfsr[1:0];
        wr(REG_CTRL, {14'h0000, fl});
        tick();
        if (mid) rd(REG_STATUS, CODE_BUSY);
        n = 0;
        while (irq_out !== 1'b1 && n < 20000) begin
            @(negedge core_clk_in);
            n++;
        end
        rd(REG_IRQ_STATUS, {14'h0000, code != CODE_OK, 1'b1});
        rd(REG_STATUS, code);
        rd(REG_CTRL, 16'h0000);
    endtask

    task automatic fill();
        for (int i = 0; i < 2048; i++) begin
            lfsr = nxt(lfsr);
            darr[i] = lfsr;
        end
    endtask

    task automatic cmp_arr();
        for (int i = 0; i < 2048; i++) begin
            check(darr[i], snap[i]);
        end
    endtask

    task automatic complete_run();
        $display("mismatches %0d checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        fill();
        rst();
        rd(REG_STATUS, RST_WORD);
        rd(REG_IRQ_STATUS, RST_WORD);
        wr(REG_STATUS, 16'hffff);
        wr(8'h1c, 16'hffff);
        rd(REG_STATUS, RST_WORD);
        rd(8'h1c, 16'h0000);
        snap = darr;
        for (int i = 0; i < 8; i++) begin
            model_small_in <= tbl[i][0][0];
            wr(REG_START, 16'(tbl[i][1]));
            wr(REG_COUNT, 16'(tbl[i][2]));
            rd(REG_START, 16'(tbl[i][1]));
            op(2'h2, 16'(tbl[i][3]), 1'b0);
        end
        cart_only_in <= 1'b1;
        cart_present_in <= 1'b0;
        op(2'h1, CODE_NO_ACCESS, 1'b0);
        op(2'h2, CODE_NO_ACCESS, 1'b0);
        cart_present_in <= 1'b1;
        cmp_arr();
        model_small_in <= 1'b1;
        op(2'h1, CODE_OK, 1'b1);
        for (int i = 0; i < 401; i++) begin
            check(store.mem[i], i < 400 ? darr[i] : 16'h0000);
        end
        snap = darr;
        fill();
        for (int i = 0; i < 2048; i++) begin
            if (i < 100 || i > 179) snap[i] = darr[i];
        end
        wr(REG_START, 16'h0064);
        wr(REG_COUNT, 16'h0050);
        op(2'h2, CODE_OK, 1'b0);
        cmp_arr();
        fill();
        snap = darr;
        wr(REG_START, 16'h0000);
        wr(REG_COUNT, 16'h0190);
        op(2'h3, CODE_OK, 1'b0);
        for (int i = 0; i < 400; i++) begin
            check(store.mem[i], snap[i]);
        end
        cmp_arr();
        wr(REG_CTRL, 16'h0001);
        tick();
        repeat (300) @(posedge core_clk_in);
        rst();
        wr(REG_COUNT, 16'h0001);
        op(2'h2, CODE_NO_IMAGE, 1'b0);
        cmp_arr();
        fail_in <= 1'b1;
        op(2'h1, CODE_NO_ACCESS, 1'b0);
        fail_in <= 1'b0;
        model_small_in <= 1'b0;
        op(2'h1, CODE_OK, 1'b0);
        for (int i = 0; i < 2001; i++) begin
            check(store.mem[i], i < 2000 ? darr[i] : VALID_MARK);
        end
        wr(REG_IRQ_MASK, 16'h0000);
        wr(REG_COUNT, 16'h0000);
        wr(REG_CTRL, 16'h0002);
        tick();
        repeat (3) @(posedge core_clk_in);
        check({15'h0000, irq_out}, 16'h0000);
        rd(REG_IRQ_STATUS, 16'h0003);
        rd(REG_IRQ_STATUS, 16'h0000);
        rd(REG_STATUS, CODE_BAD_ARGS);
        repeat (3) @(posedge core_clk_in);
        complete_run();
    end
endmodule
